//--- pkg/sea_pkg.sv
// Constants, field layouts and state codes for the serial EEPROM autoloader.
// Assumes a 25 MHz core clock and a standard SPI serial EEPROM with 16-bit byte addressing.
package sea_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int MCLK_PERIOD_NS = 40;
	localparam int SCK_HALF_NS = 160;
	localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int WRITE_TIME_NS = 5000000;
	localparam int WRITE_CYCLES_DEFAULT = WRITE_TIME_NS / MCLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// SPI command codes and frame sizes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [5:0] FRAME_BITS = 6'h28;
	localparam logic [5:0] WREN_BITS = 6'h08;

	// ----------------------------------------------------------------
	// EEPROM word indices (byte offset is twice the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] WORD_SIG = 8'h00;
	localparam logic [7:0] WORD_BUF_SET5 = 8'h0e;
	localparam logic [7:0] WORD_DESKEW_FIRST = 8'h10;
	localparam logic [7:0] WORD_DESKEW_LAST = 8'h15;
	localparam logic [7:0] WORD_PM0 = 8'h28;
	localparam logic [7:0] WORD_LAST = 8'h28;

	// Signature value is arbitrary and stands for the expected marker word.
	localparam logic [15:0] SIGNATURE = 16'ha55a;

	// ----------------------------------------------------------------
	// Reset values of the loaded configuration fields
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BUF_CTRL = 8'h00;
	localparam logic [7:0] RST_SET5_HI = 8'h00;
	localparam logic [15:0] RST_DESKEW = 16'h0000;
	localparam logic [7:0] RST_PM_DATA = 8'h00;
	localparam logic [7:0] RST_PM_CAP = 8'h00;
	localparam int NUM_PORTS = 6;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WREN = 3'h1,
		ST_WREN_WAIT = 3'h2,
		ST_ISSUE = 3'h3,
		ST_XFER = 3'h4,
		ST_WRITE_TIME = 3'h5
	} sea_state_type;

endpackage

//--- pkg/sea_spi_if.sv
// Link between the autoload sequencer and its SPI shift engine.
// Both ends run on mclk; miso arrives already synchronised.
`timescale 1ns/1ps
interface sea_spi_if;
	logic start;
	logic [5:0] nbits;
	logic [39:0] tx;
	logic busy;
	logic done;
	logic [15:0] rx;
	logic sck;
	logic csN;
	logic mosi;
	logic miso;

	modport sequencer (output start, output nbits, output tx, output miso,
		input busy, input done, input rx, input sck, input csN, input mosi);
	modport engine (input start, input nbits, input tx, input miso,
		output busy, output done, output rx, output sck, output csN, output mosi);
endinterface // sea_spi_if

//--- logic/sea_spi_engine.sv
// SPI mode 0 master shifting one left-aligned frame of up to 40 bits.
// Assumes start is raised only while busy is low; miso is already synchronised.
`timescale 1ns/1ps
module sea_spi_engine
	import sea_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	sea_spi_if.engine spi
);

	logic [2:0] divCnt;
	logic [5:0] bitsLeft;
	logic [39:0] shift;

	assign spi.busy = ~spi.csN;

	// Each half period the clock toggles; input is sampled on the rise, output moves on the fall.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			spi.csN <= 1'b1;
			spi.sck <= 1'b0;
			spi.mosi <= 1'b0;
			spi.done <= 1'b0;
			spi.rx <= 16'h0000;
			divCnt <= 3'h0;
			bitsLeft <= 6'h00;
			shift <= 40'h0;
		end else begin
			spi.done <= 1'b0;
			if (spi.csN) begin
				if (spi.start) begin
					spi.csN <= 1'b0;
					spi.sck <= 1'b0;
					shift <= spi.tx;
					spi.mosi <= spi.tx[39];
					bitsLeft <= spi.nbits;
					divCnt <= 3'h0;
				end
			end else if (divCnt == 3'(SCK_HALF_CYCLES - 1)) begin
				divCnt <= 3'h0;
				if (!spi.sck) begin
					spi.sck <= 1'b1;
					spi.rx <= {spi.rx[14:0], spi.miso};
				end else begin
					spi.sck <= 1'b0;
					shift <= {shift[38:0], 1'b0};
					spi.mosi <= shift[38];
					bitsLeft <= bitsLeft - 6'h01;
					// Chip select lifts on the last falling edge, so the memory sees a clean frame end.
					if (bitsLeft == 6'h01) begin
						spi.csN <= 1'b1;
						spi.mosi <= 1'b0;
						spi.done <= 1'b1;
					end
				end
			end else begin
				divCnt <= divCnt + 3'h1;
			end
		end
	end

endmodule // sea_spi_engine

//--- logic/sea_autoload.sv
// Serial EEPROM autoloader: signature check, configuration load and software word access.
// Assumes a single standard SPI serial EEPROM on the four rom pins; all other inputs except fundamental_reset_n are on mclk.
`timescale 1ns/1ps

// Behaviour
// - Four EEPROM pins: serial clock, data out, data in, chip select.
// - Act as SPI master using standard serial EEPROM command codes.
// - After fundamental reset release, load configuration from EEPROM before enumeration.
// - Storage is 16-bit words, each access carries an 8-bit word address.
// - A hardware sequencer performs each software access as one whole word transfer.
// - Start, word address and read or write command are software-visible controls.
// - First word is a signature; autoload runs only when it matches.
// - Autoload reads successive words and writes each to its mapped field.
// - Autoload completion sets the status bit (bit 4 at A0h) to one.
// - Word 1Ch high byte to buffer control, low byte to set five bits 23:16.
// - Words 20h to 2Ah give per-port deskew mode and set two bits.
// - Word 50h carries port zero power-management data high, capability low.
module sea_autoload
	import sea_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEFAULT
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fundamental_reset_n,
	output logic romSerialClock,
	output logic romSerialOut,
	input wire logic romSerialIn,
	output logic romChipSelectN,
	input wire logic swStart,
	input wire logic swWrite,
	input wire logic [7:0] swAddr,
	input wire logic [15:0] swWriteData,
	output logic [15:0] swReadData,
	output logic swBusy,
	output logic autoloadStatus,
	output logic signatureValid,
	output logic [7:0] bufferCtrl,
	output logic [7:0] transceiverCtrlSet5Hi,
	output logic [NUM_PORTS-1:0][15:0] deskewSet2,
	output logic [7:0] pmData0,
	output logic [7:0] pmCap0
);

	// ----------------------------------------------------------------
	// Frame construction
	// ----------------------------------------------------------------

	// word address
	// Byte address is the word index doubled; the upper seven address bits are always zero.
	function automatic logic [39:0] frame(input logic [7:0] cmd, input logic [7:0] wordAddr,
		input logic [15:0] data);
		frame = {cmd, 7'h00, wordAddr, 1'b0, data};
	endfunction

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------

	sea_spi_if spi ();
	logic fundSync1, fundSync2, fundPrev;
	logic misoSync1, misoSync2;

	// Both pin inputs pass two flops; the reset input adds a third flop, fundPrev, for edge detection.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fundSync1 <= 1'b0;
			fundSync2 <= 1'b0;
			fundPrev <= 1'b0;
			misoSync1 <= 1'b0;
			misoSync2 <= 1'b0;
		end else begin
			fundSync1 <= fundamental_reset_n;
			fundSync2 <= fundSync1;
			fundPrev <= fundSync2;
			misoSync1 <= romSerialIn;
			misoSync2 <= misoSync1;
		end
	end

	assign spi.miso = misoSync2;

	sea_spi_engine engine (
		.mclk(mclk),
		.rst_n(rst_n),
		.spi(spi)
	);

	assign romSerialClock = spi.sck;
	assign romSerialOut = spi.mosi;
	assign romChipSelectN = spi.csN;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------

	sea_state_type state;
	logic loading;
	logic opWrite;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [16:0] waitCnt;
	logic [7:0] deskewIdx;

	assign deskewIdx = addr - WORD_DESKEW_FIRST;

	// Holding the sequencer idle during fundamental reset aborts any load in flight.
	always_ff @(posedge mclk) begin
		if (!rst_n || !fundSync2) begin
			state <= ST_IDLE;
			loading <= 1'b0;
			opWrite <= 1'b0;
			addr <= 8'h00;
			wdata <= 16'h0000;
			waitCnt <= 17'h0;
			swBusy <= 1'b0;
			autoloadStatus <= 1'b0;
			signatureValid <= 1'b0;
			spi.start <= 1'b0;
			spi.nbits <= FRAME_BITS;
			spi.tx <= 40'h0;
		end else begin
			spi.start <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (!fundPrev) begin
						loading <= 1'b1;
						opWrite <= 1'b0;
						addr <= WORD_SIG;
						state <= ST_ISSUE;
					end else if (swStart && autoloadStatus) begin
						opWrite <= swWrite;
						addr <= swAddr;
						wdata <= swWriteData;
						swBusy <= 1'b1;
						state <= swWrite ? ST_WREN : ST_ISSUE;
					end
				end
				ST_WREN: begin
					if (!spi.busy) begin
						spi.start <= 1'b1;
						spi.nbits <= WREN_BITS;
						spi.tx <= {CMD_WREN, 32'h0};
						state <= ST_WREN_WAIT;
					end
				end
				ST_WREN_WAIT: begin
					if (spi.done) begin
						state <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					if (!spi.busy) begin
						spi.start <= 1'b1;
						spi.nbits <= FRAME_BITS;
						spi.tx <= opWrite ? frame(CMD_WRITE, addr, wdata) : frame(CMD_READ, addr, 16'h0000);
						state <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (spi.done) begin
						if (loading) begin
							if (addr == WORD_SIG && spi.rx != SIGNATURE) begin
								loading <= 1'b0;
								autoloadStatus <= 1'b1;
								state <= ST_IDLE;
							end else if (addr == WORD_LAST) begin
								loading <= 1'b0;
								autoloadStatus <= 1'b1;
								state <= ST_IDLE;
							end else begin
								signatureValid <= 1'b1;
								addr <= addr + 8'h01;
								state <= ST_ISSUE;
							end
						end else if (opWrite) begin
							waitCnt <= 17'h0;
							state <= ST_WRITE_TIME;
						end else begin
							swBusy <= 1'b0;
							state <= ST_IDLE;
						end
					end
				end
				ST_WRITE_TIME: begin
					// The memory is not polled; busy covers its worst-case internal write time.
					if (waitCnt == 17'(WRITE_CYCLES - 1)) begin
						swBusy <= 1'b0;
						state <= ST_IDLE;
					end else begin
						waitCnt <= waitCnt + 17'h1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Software read data is captured when a read frame completes.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			swReadData <= 16'h0000;
		end else if (state == ST_XFER && spi.done && !loading && !opWrite) begin
			swReadData <= spi.rx;
		end
	end

	// ----------------------------------------------------------------
	// Loaded configuration fields
	// ----------------------------------------------------------------

	// Fields return to defaults on fundamental reset so a skipped load leaves them untouched.
	always_ff @(posedge mclk) begin
		if (!rst_n || !fundSync2) begin
			bufferCtrl <= RST_BUF_CTRL;
			transceiverCtrlSet5Hi <= RST_SET5_HI;
			deskewSet2 <= {NUM_PORTS{RST_DESKEW}};
			pmData0 <= RST_PM_DATA;
			pmCap0 <= RST_PM_CAP;
		end else if (state == ST_XFER && spi.done && loading) begin
			if (addr == WORD_BUF_SET5) begin
				bufferCtrl <= spi.rx[15:8];
				transceiverCtrlSet5Hi <= spi.rx[7:0];
			end
			if (addr >= WORD_DESKEW_FIRST && addr <= WORD_DESKEW_LAST) begin
				deskewSet2[deskewIdx[2:0]] <= spi.rx;
			end
			if (addr == WORD_PM0) begin
				pmData0 <= spi.rx[15:8];
				pmCap0 <= spi.rx[7:0];
			end
		end
	end

endmodule // sea_autoload

//--- tb/sea_autoload_assertions.sv
// Concurrent checks on the autoloader's pins and status outputs.
// Assumes the sea_autoload top with everything on mclk.
`timescale 1ns/1ps
module sea_autoload_assertions
	import sea_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fundamental_reset_n,
	input wire logic romSerialClock,
	input wire logic romSerialOut,
	input wire logic romChipSelectN,
	input wire logic swStart,
	input wire logic swBusy,
	input wire logic autoloadStatus,
	input wire logic signatureValid,
	input wire logic [7:0] bufferCtrl,
	input wire logic [7:0] pmData0,
	input wire logic [7:0] pmCap0,
	input wire logic [NUM_PORTS-1:0][15:0] deskewSet2
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_sck_idle; romChipSelectN |-> !romSerialClock; endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("serial clock not idle low");
	property p_first_rise; $fell(romChipSelectN) |-> !romSerialClock [*4] ##1 romSerialClock; endproperty
	a_first_rise: assert property (p_first_rise) else $error("first clock rise misplaced");
	property p_sck_high; $rose(romSerialClock) |-> romSerialClock [*4] ##1 !romSerialClock; endproperty
	a_sck_high: assert property (p_sck_high) else $error("clock high phase wrong");
	property p_sck_low; $fell(romSerialClock) && !romChipSelectN |-> !romSerialClock [*4] ##1 romSerialClock; endproperty
	a_sck_low: assert property (p_sck_low) else $error("clock low phase wrong");
	// Data may only move on a falling clock, so the memory samples it settled.
	property p_mosi_fall; !romChipSelectN && $past(!romChipSelectN) && $changed(romSerialOut) |-> $fell(romSerialClock);
	endproperty
	a_mosi_fall: assert property (p_mosi_fall) else $error("data out moved off the falling clock");
	property p_busy_start; swStart && autoloadStatus && !swBusy |=> swBusy; endproperty
	a_busy_start: assert property (p_busy_start) else $error("accepted start without busy");
	property p_gate; swBusy |-> autoloadStatus; endproperty
	a_gate: assert property (p_gate) else $error("access ran before load finished");
	property p_hold; autoloadStatus && $past(autoloadStatus) |-> $stable(bufferCtrl) && $stable(pmData0); endproperty
	a_hold: assert property (p_hold) else $error("loaded field moved after completion");
	property p_defaults; $rose(autoloadStatus) && !signatureValid |-> bufferCtrl == RST_BUF_CTRL &&
		pmCap0 == RST_PM_CAP && deskewSet2[0] == RST_DESKEW; endproperty
	a_defaults: assert property (p_defaults) else $error("fields not default on bad signature");
	property p_clear; $fell(autoloadStatus) |-> !$past(fundamental_reset_n, 2) || !$past(fundamental_reset_n, 3) ||
		!$past(fundamental_reset_n, 4); endproperty
	a_clear: assert property (p_clear) else $error("status dropped without reset");
endmodule // sea_autoload_assertions
bind sea_autoload sea_autoload_assertions u_chk (.mclk, .rst_n, .fundamental_reset_n, .romSerialClock,
	.romSerialOut, .romChipSelectN, .swStart, .swBusy, .autoloadStatus, .signatureValid, .bufferCtrl,
	.pmData0, .pmCap0, .deskewSet2);

//--- tb/sea_eeprom_model.sv
// Behavioural mode 0 SPI serial memory of 256 words.
// Assumes read, write and write-enable frames with a 16-bit byte address.
`timescale 1ns/1ps
module sea_eeprom_model
	import sea_pkg::*;
(
	input wire logic sck,
	input wire logic csN,
	input wire logic mosi,
	output logic miso
);
	logic [15:0] mem [0:255];
	logic [39:0] sh = '0;
	logic [7:0] cmd = 8'h00;
	logic [7:0] addr = 8'h00;
	logic wel = 1'b0;
	int n = 0;
	initial miso = 1'b0;
	// A deselected part releases the line, so show a moving value, not the last bit.
	always @(posedge csN) miso = ~miso;
	always @(negedge csN) begin
		n = 0;
		cmd = 8'h00;
	end
	// Shift in on rising clock; writes need a prior enable frame.
	always @(posedge sck) begin
		if (!csN) begin
			sh = {sh[38:0], mosi};
			n = n + 1;
			if (n == 8 && sh[7:0] == CMD_WREN) wel = 1'b1;
			if (n == 24) begin
				cmd = sh[23:16];
				addr = sh[8:1];
			end
			if (n == 40 && cmd == CMD_WRITE && wel) begin
				mem[addr] = sh[15:0];
				wel = 1'b0;
			end
		end
	end
	always @(negedge sck) if (!csN && n >= 24 && n < 40 && cmd == CMD_READ) miso = mem[addr][39 - n];
endmodule // sea_eeprom_model

//--- tb/sea_autoload_tb.sv
// Self-checking bench for the autoloader against a serial memory model.
// Assumes a 25 MHz mclk and a shortened write wait.
`timescale 1ns/1ps
module sea_autoload_tb;
	import sea_pkg::*;
	logic mclk = 1'b0, rst_n = 1'b0, fundamental_reset_n = 1'b1, swStart = 1'b0, swWrite = 1'b0;
	logic [7:0] swAddr = 8'h00;
	logic [15:0] swWriteData = 16'h0000;
	logic romSerialClock, romSerialOut, romSerialIn, romChipSelectN, swBusy, autoloadStatus, signatureValid;
	logic [15:0] swReadData;
	logic [7:0] bufferCtrl, transceiverCtrlSet5Hi, pmData0, pmCap0;
	logic [NUM_PORTS-1:0][15:0] deskewSet2;
	int err_total = 0, n_compared = 0, seed;
	always #20 mclk = ~mclk;
	sea_autoload #(.WRITE_CYCLES(20)) dut (.mclk, .rst_n, .fundamental_reset_n, .romSerialClock, .romSerialOut,
		.romSerialIn, .romChipSelectN, .swStart, .swWrite, .swAddr, .swWriteData, .swReadData, .swBusy,
		.autoloadStatus, .signatureValid, .bufferCtrl, .transceiverCtrlSet5Hi, .deskewSet2, .pmData0, .pmCap0);
	sea_eeprom_model rom (.sck(romSerialClock), .csN(romChipSelectN), .mosi(romSerialOut), .miso(romSerialIn));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] word_at(input logic [7:0] byteOff);
		return rom.mem[byteOff >> 1];
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Every wait is bounded so a stuck sequencer ends the run.
	task automatic wait_until(input bit busyWait, input int lim);
		int k = 0;
		while ((busyWait ? swBusy !== 1'b0 : autoloadStatus !== 1'b1) && k < lim) begin
			@(posedge mclk);
			k++;
		end
		if (k >= lim) begin
			err_total++;
			$display("wrong value at %0t ns: wait ran out", $time);
			complete_run();
		end
	endtask
	task automatic check_fields(input bit loaded);
		chk({15'h0000, signatureValid}, {15'h0000, loaded});
		chk({bufferCtrl, transceiverCtrlSet5Hi}, loaded ? word_at(8'h1c) : {RST_BUF_CTRL, RST_SET5_HI});
		chk({pmData0, pmCap0}, loaded ? word_at(8'h50) : {RST_PM_DATA, RST_PM_CAP});
		for (int p = 0; p < NUM_PORTS; p++) chk(deskewSet2[p], loaded ? word_at(8'(8'h20 + 2 * p)) : RST_DESKEW);
	endtask
	// Pulse the fundamental reset and try an early access, which must be ignored.
	task automatic reload(input logic [15:0] sig);
		rom.mem[0] = sig;
		fundamental_reset_n <= 1'b0;
		repeat (5) @(posedge mclk);
		fundamental_reset_n <= 1'b1;
		swStart <= 1'b1;
		@(posedge mclk);
		swStart <= 1'b0;
		repeat (4) @(posedge mclk);
		chk({14'h0000, swBusy, autoloadStatus}, 16'h0000);
		wait_until(1'b0, 20000);
	endtask
	// A second start while busy, at the inverted address, must be refused.
	task automatic sw_op(input logic w, input logic [7:0] a, input logic [15:0] d);
		swWrite <= w;
		swAddr <= a;
		swWriteData <= d;
		swStart <= 1'b1;
		@(posedge mclk);
		swStart <= 1'b0;
		repeat (3) @(posedge mclk);
		swAddr <= ~a;
		swStart <= 1'b1;
		@(posedge mclk);
		swStart <= 1'b0;
		wait_until(1'b1, 2000);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] a;
		logic [15:0] d;
		seed = $urandom(36);
		for (int i = 0; i < 256; i++) rom.mem[i] = 16'($urandom);
		rom.mem[0] = SIGNATURE ^ 16'h0001;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		wait_until(1'b0, 20000);
		check_fields(1'b0);
		// Cut a matching load mid-frame; the engine ends the frame and the next reload must still finish.
		rom.mem[0] = SIGNATURE;
		fundamental_reset_n <= 1'b0;
		repeat (5) @(posedge mclk);
		fundamental_reset_n <= 1'b1;
		repeat (2000) @(posedge mclk);
		chk({15'h0000, autoloadStatus}, 16'h0000);
		reload(SIGNATURE);
		check_fields(1'b1);
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 8'hff : 8'($urandom);
			d = 16'($urandom);
			sw_op(1'b1, a, d);
			chk(rom.mem[a], d);
			sw_op(1'b0, a, 16'h0000);
			chk(swReadData, d);
		end
		complete_run();
	end
endmodule // sea_autoload_tb
